// >>> include/gpe_pkg.sv
// constants and types shared by the second-stage entry checker
// Behaviour
// - write-only or write-execute permission is misconfigured
// - execute-only misconfigured unless the implementation supports it
// - present entry with reserved bit set is misconfigured
// - leaf entry with reserved memory type misconfigured
// - misconfiguration always beats permission violation
// - checks fire only on real table accesses
// - pae pointer loads pass through the checker
// - convert control turns violations into virtualization exceptions
// - leaf bits 0,1,2 grant read, write, fetch
// - leaf bits 5:3 memory type, bit 6 ignore-attribute
// - accessed/dirty valid only with root pointer bit 6
// - leaf bits up to width-1 give page address
// - high address bits reserved, other bits ignored
// - leaf bit 63 suppresses exception conversion
// - every entry of the walk is checked
// - zero permission bits mean not present, violation
// - missing read bit on any entry violates reads
// - with accessed/dirty on, table reads checked as writes; pae pointer loads stay reads
package gpe_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_ROOT     = 8'h04;
    localparam logic [7:0] OFF_CAP      = 8'h08;
    localparam logic [7:0] OFF_COUNTS   = 8'h0C;
    localparam logic [7:0] OFF_LAST     = 8'h10;
    // field positions
    localparam int CTRL_CONVERT_BIT = 0;
    localparam int ROOT_AD_BIT      = 6;
    localparam int ENT_R_BIT        = 0;
    localparam int ENT_W_BIT        = 1;
    localparam int ENT_X_BIT        = 2;
    localparam int ENT_MT_LSB       = 3;
    localparam int ENT_IPAT_BIT     = 6;
    localparam int ENT_BIG_BIT      = 7;
    localparam int ENT_ACC_BIT      = 8;
    localparam int ENT_DIRTY_BIT    = 9;
    localparam int ENT_ADDR_LSB     = 12;
    localparam int ENT_ADDR_MSB     = 51;
    localparam int ENT_SVE_BIT      = 63;
    // reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] ROOT_RST = 32'h0000_0000;
    // permission encodings
    localparam logic [2:0] PERM_NONE  = 3'h0;
    localparam logic [2:0] PERM_WO    = 3'h2;
    localparam logic [2:0] PERM_WX    = 3'h6;
    localparam logic [2:0] PERM_XO    = 3'h4;
    // reserved memory types
    localparam logic [2:0] MT_RSV_A   = 3'h2;
    localparam logic [2:0] MT_RSV_B   = 3'h3;
    localparam logic [2:0] MT_RSV_C   = 3'h7;
    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // walk levels, 0 is the leaf table
    typedef enum logic [1:0] {LVL_LEAF, LVL_DIR, LVL_PTR, LVL_TOP} level_t;
    typedef enum logic [1:0] {ACC_READ, ACC_WRITE, ACC_FETCH} acc_t;
    typedef enum logic [1:0] {RES_NOTPRES, RES_MISCONF, RES_VIOL, RES_OK} res_code_t;
endpackage : gpe_pkg

// >>> hdl/entry_classifier.sv
// combinational classification of one translation entry
`timescale 1ns/1ns
`default_nettype none
module entry_classifier #(
    parameter int PA_WIDTH = 46
) (
    // entry under test
    input  wire logic [63:0]          entry,
    input  wire gpe_pkg::level_t      level,
    input  wire logic                 exec_only_ok,
    // verdict
    output logic                      present,
    output logic                      leaf,
    output logic                      misconf
);
    import gpe_pkg::*;

    // reserved bits that depend on the level and page size
    function automatic logic [63:0] rsv_mask(input level_t lv, input logic big);
        logic [63:0] m;
        m = '0;
        for (int i = ENT_ADDR_LSB; i <= ENT_ADDR_MSB; i++) begin
            if (i >= PA_WIDTH) m[i] = 1'b1;
        end
        case (lv)
            LVL_LEAF: m = m;
            LVL_DIR:  m = big ? (m | 64'h0000_0000_001F_F000) : (m | 64'h0000_0000_0000_0078);
            LVL_PTR:  m = big ? (m | 64'h0000_0000_3FFF_F000) : (m | 64'h0000_0000_0000_0078);
            default:  m = m | 64'h0000_0000_0000_00F8;
        endcase
        return m;
    endfunction : rsv_mask

    wire logic [2:0] perm    = entry[ENT_X_BIT:ENT_R_BIT];
    wire logic [2:0] mtype   = entry[ENT_MT_LSB+2:ENT_MT_LSB];
    wire logic       big     = entry[ENT_BIG_BIT];
    wire logic       perm_bad = (perm == PERM_WO) || (perm == PERM_WX)
                              || ((perm == PERM_XO) && !exec_only_ok);
    wire logic       rsv_bad = |(entry & rsv_mask(level, big));
    wire logic       mt_bad  = (mtype == MT_RSV_A) || (mtype == MT_RSV_B) || (mtype == MT_RSV_C);

    // the low three bits alone decide presence; the rest is ignored when zero
    assign present = (perm != PERM_NONE);
    assign leaf    = (level == LVL_LEAF) || ((level == LVL_DIR || level == LVL_PTR) && big);
    assign misconf = present && (perm_bad || rsv_bad || (leaf && mt_bad));
endmodule : entry_classifier
`default_nettype wire

// >>> hdl/event_counter.sv
// saturating counter of one-cycle event pulses
`timescale 1ns/1ns
`default_nettype none
module event_counter #(
    parameter int WIDTH = 16
) (
    // clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // event in, count out
    input  wire logic             pulse,
    output logic [WIDTH-1:0]      count
);
    // saturates instead of wrapping so software never sees a false small count
    wire logic [WIDTH-1:0] count_nxt = (pulse && !(&count)) ? count + 1'b1 : count;

    always_ff @(posedge aclk) begin
        if (!aresetn) count <= '0;
        else          count <= count_nxt;
    end
endmodule : event_counter
`default_nettype wire

// >>> hdl/guest_phys_entry_checker.sv
// second-stage translation entry checker with axi4-lite control registers
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module guest_phys_entry_checker #(
    parameter int   PA_WIDTH     = 46,
    parameter logic EXEC_ONLY_OK = 1'b1,
    parameter int   CNT_WIDTH    = 16
) (
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // axi4-lite write address
    input  wire logic [7:0]        awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    // axi4-lite write data
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    // axi4-lite write response
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // axi4-lite read
    input  wire logic [7:0]        araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // entry from the walker
    input  wire logic              ent_valid,
    input  wire logic [63:0]       ent_data,
    input  wire gpe_pkg::level_t   ent_level,
    input  wire gpe_pkg::acc_t     ent_acc,
    input  wire logic              ent_table,
    input  wire logic              ent_pae_load,
    // per-entry result
    output logic                   res_valid,
    output gpe_pkg::res_code_t     res_code,
    output logic                   res_leaf,
    // leaf decode
    output logic [51:0]            page_addr,
    output logic [2:0]             mem_type,
    output logic                   ignore_attr,
    output logic                   accessed,
    output logic                   dirty,
    output logic                   suppress_vexc,
    // events to the exit logic
    output logic                   misconf_evt,
    output logic                   viol_exit_evt,
    output logic                   vexc_evt
);
    import gpe_pkg::*;

    // ---------------- registers ----------------
    logic [31:0]          ctrl_r;
    logic [31:0]          root_r;
    logic [7:0]           last_r;
    logic [CNT_WIDTH-1:0] mis_cnt;
    logic [CNT_WIDTH-1:0] vio_cnt;

    wire logic convert_on = ctrl_r[CTRL_CONVERT_BIT];
    wire logic ad_on      = root_r[ROOT_AD_BIT];

    // ---------------- classification ----------------
    logic cls_present;
    logic cls_leaf;
    logic cls_misconf;

    entry_classifier #(.PA_WIDTH(PA_WIDTH)) u_cls (
        .entry        (ent_data),
        .level        (ent_level),
        .exec_only_ok (EXEC_ONLY_OK),
        .present      (cls_present),
        .leaf         (cls_leaf),
        .misconf      (cls_misconf)
    );

    // access needs; pae pointer loads stay reads even with accessed/dirty on
    wire logic need_w = (ent_acc == ACC_WRITE)
                      || (ent_table && ad_on && !ent_pae_load);
    wire logic need_r = (ent_acc == ACC_READ) || ent_table;
    wire logic need_x = (ent_acc == ACC_FETCH);
    wire logic perm_miss = (need_r && !ent_data[ENT_R_BIT])
                         || (need_w && !ent_data[ENT_W_BIT])
                         || (need_x && !ent_data[ENT_X_BIT]);
    wire logic is_mis  = cls_present && cls_misconf;
    wire logic is_viol = !is_mis && (!cls_present || perm_miss);
    wire logic to_vexc = is_viol && convert_on && !ent_data[ENT_SVE_BIT];

    wire res_code_t code_nxt = !cls_present ? RES_NOTPRES :
                               is_mis       ? RES_MISCONF :
                               is_viol      ? RES_VIOL    : RES_OK;

    // result and events, one cycle after each presented entry
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            res_valid     <= 1'b0;
            res_code      <= RES_NOTPRES;
            res_leaf      <= 1'b0;
            misconf_evt   <= 1'b0;
            viol_exit_evt <= 1'b0;
            vexc_evt      <= 1'b0;
        end else begin
            res_valid     <= ent_valid;
            res_code      <= ent_valid ? code_nxt : res_code;
            res_leaf      <= ent_valid && cls_leaf;
            misconf_evt   <= ent_valid && is_mis;
            viol_exit_evt <= ent_valid && is_viol && !to_vexc;
            vexc_evt      <= ent_valid && to_vexc;
        end
    end

    // leaf decode; address bits above the width are never passed on
    wire logic [51:0] addr_mask = 52'hF_FFFF_FFFF_FFFF >> (52 - PA_WIDTH);
    wire logic [51:0] addr_nxt  = {ent_data[ENT_ADDR_MSB:ENT_ADDR_LSB], 12'h000}
                                & addr_mask & 52'hF_FFFF_FFFF_F000;
    wire logic        leaf_take = ent_valid && cls_leaf && cls_present;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            page_addr   <= '0;
            mem_type    <= 3'h0;
            ignore_attr   <= 1'b0;
            accessed      <= 1'b0;
            dirty         <= 1'b0;
            suppress_vexc <= 1'b0;
        end else if (leaf_take) begin
            page_addr   <= addr_nxt;
            mem_type    <= ent_data[ENT_MT_LSB+2:ENT_MT_LSB];
            ignore_attr <= ent_data[ENT_IPAT_BIT];
            accessed    <= ad_on && ent_data[ENT_ACC_BIT];
            dirty       <= ad_on && ent_data[ENT_DIRTY_BIT];
            suppress_vexc <= convert_on && ent_data[ENT_SVE_BIT];
        end
    end

    // ---------------- event counters ----------------
    event_counter #(.WIDTH(CNT_WIDTH)) u_mis_cnt (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pulse   (misconf_evt),
        .count   (mis_cnt)
    );

    event_counter #(.WIDTH(CNT_WIDTH)) u_vio_cnt (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pulse   (viol_exit_evt | vexc_evt),
        .count   (vio_cnt)
    );

    // last result seen, for software inspection
    always_ff @(posedge aclk) begin
        if (!aresetn)       last_r <= 8'h00;
        else if (res_valid) last_r <= {3'h0, res_leaf, 2'h0, res_code};
    end

    // ---------------- axi4-lite write path ----------------
    logic        aw_got_r;
    logic        w_got_r;
    logic [7:0]  aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] m;
        m = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) m[b*8 +: 8] = nw[b*8 +: 8];
        end
        return m;
    endfunction : merge

    wire logic aw_take  = awvalid && awready;
    wire logic w_take   = wvalid && wready;
    // address and data may come in either order; commit once both are held
    wire logic do_wr    = aw_got_r && w_got_r && !bvalid;
    wire logic aw_g_nxt = (aw_got_r || aw_take) && !do_wr;
    wire logic w_g_nxt  = (w_got_r || w_take) && !do_wr;
    wire logic wr_ctrl  = do_wr && (aw_addr_r == OFF_CTRL);
    wire logic wr_root  = do_wr && (aw_addr_r == OFF_ROOT);
    wire logic wr_known = wr_ctrl || wr_root || (aw_addr_r == OFF_CAP)
                        || (aw_addr_r == OFF_COUNTS) || (aw_addr_r == OFF_LAST);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r  <= 1'b0;
            w_got_r   <= 1'b0;
            awready   <= 1'b0;
            wready    <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r  <= 32'h0000_0000;
            w_strb_r  <= 4'h0;
        end else begin
            aw_got_r  <= aw_g_nxt;
            w_got_r   <= w_g_nxt;
            awready   <= !aw_g_nxt;
            wready    <= !w_g_nxt;
            aw_addr_r <= aw_take ? awaddr : aw_addr_r;
            w_data_r  <= w_take ? wdata : w_data_r;
            w_strb_r  <= w_take ? wstrb : w_strb_r;
        end
    end

    // register writes and write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= CTRL_RST;
            root_r <= ROOT_RST;
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
        end else begin
            ctrl_r <= wr_ctrl ? merge(ctrl_r, w_data_r, w_strb_r) & 32'h0000_0001 : ctrl_r;
            root_r <= wr_root ? merge(root_r, w_data_r, w_strb_r) : root_r;
            bvalid <= do_wr || (bvalid && !bready);
            bresp  <= do_wr ? (wr_known ? RESP_OKAY : RESP_DECERR) : bresp;
        end
    end

    // ---------------- axi4-lite read path ----------------
    wire logic ar_take = arvalid && arready;
    wire logic [31:0] cap_word = {16'h0000, 8'(PA_WIDTH), 7'h00, EXEC_ONLY_OK};
    wire logic rd_known = (araddr == OFF_CTRL) || (araddr == OFF_ROOT) || (araddr == OFF_CAP)
                        || (araddr == OFF_COUNTS) || (araddr == OFF_LAST);
    wire logic [31:0] rd_mux =
        (araddr == OFF_CTRL)   ? ctrl_r :
        (araddr == OFF_ROOT)   ? root_r :
        (araddr == OFF_CAP)    ? cap_word :
        (araddr == OFF_COUNTS) ? {16'(vio_cnt), 16'(mis_cnt)} :
        (araddr == OFF_LAST)   ? {24'h00_0000, last_r} : 32'h0000_0000;
    wire logic rv_nxt = ar_take || (rvalid && !rready);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= RESP_OKAY;
        end else begin
            arready <= !rv_nxt;
            rvalid  <= rv_nxt;
            rdata   <= ar_take ? rd_mux : rdata;
            rresp   <= ar_take ? (rd_known ? RESP_OKAY : RESP_DECERR) : rresp;
        end
    end

    // ---------------- assertions ----------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_write_only_cfg: assert property (
        ent_valid && (ent_data[2:0] == PERM_WO || ent_data[2:0] == PERM_WX)
        |=> misconf_evt && res_code == RES_MISCONF)
        else $error("write-only permission not flagged");

    a_exec_only_cfg: assert property (
        ent_valid && ent_data[2:0] == PERM_XO && ent_level == LVL_LEAF
        && ent_data[5:3] == 3'h6 && ent_data[ENT_ADDR_MSB:PA_WIDTH] == '0
        |=> (misconf_evt == !EXEC_ONLY_OK))
        else $error("execute-only handling wrong");

    a_rsv_addr_cfg: assert property (
        ent_valid && ent_data[2:0] != PERM_NONE && |ent_data[ENT_ADDR_MSB:PA_WIDTH]
        |=> res_code == RES_MISCONF)
        else $error("reserved address bit not flagged");

    a_memtype_cfg: assert property (
        ent_valid && ent_level == LVL_LEAF && ent_data[2:0] == 3'h1 && ent_data[5:3] == MT_RSV_C
        |=> misconf_evt)
        else $error("reserved memory type not flagged");

    a_misconf_wins: assert property (
        misconf_evt |-> !viol_exit_evt && !vexc_evt && res_code == RES_MISCONF)
        else $error("violation reported beside misconfiguration");

    a_idle_quiet: assert property (
        !ent_valid |=> !res_valid && !misconf_evt && !viol_exit_evt && !vexc_evt)
        else $error("event without an entry access");

    a_notpres_viol: assert property (
        ent_valid && ent_data[2:0] == PERM_NONE
        |=> res_code == RES_NOTPRES && (viol_exit_evt || vexc_evt))
        else $error("not-present entry not a violation");

    a_table_write: assert property (
        ent_valid && ent_table && !ent_pae_load && ad_on
        && (ent_data[2:0] == 3'h1 || ent_data[2:0] == 3'h5) && ent_data[51:3] == '0
        |=> res_code == RES_VIOL)
        else $error("table access not checked as write");

    a_vexc_suppress: assert property (
        vexc_evt |-> $past(convert_on) && !$past(ent_data[ENT_SVE_BIT]))
        else $error("exception conversion despite suppress bit");

    // flags may hold a stale value from an older leaf; only a fresh leaf is judged
    a_ad_ignored: assert property (
        leaf_take && !ad_on |=> !accessed && !dirty)
        else $error("accessed/dirty shown while disabled");

    a_pulse_once: assert property (
        ent_valid ##1 !ent_valid |=> !res_valid)
        else $error("result strobe longer than one cycle");
endmodule : guest_phys_entry_checker
`default_nettype wire

// >>> testbench/walker_model.sv
// page-table walker model that feeds translation entries to the checker
`timescale 1ns/1ns
`default_nettype none
module walker_model (
    // clock
    input  wire logic            aclk,
    // entry toward the checker
    output var logic             ent_valid,
    output var logic [63:0]      ent_data,
    output var gpe_pkg::level_t  ent_level,
    output var gpe_pkg::acc_t    ent_acc,
    output var logic             ent_table,
    output var logic             ent_pae_load
);
    import gpe_pkg::*;

    // idle until the first entry is fetched
    initial begin
        ent_valid    = 1'b0;
        ent_data     = 64'h5555_5555_5555_5555;
        ent_level    = LVL_LEAF;
        ent_acc      = ACC_READ;
        ent_table    = 1'b0;
        ent_pae_load = 1'b0;
    end

    // one strobe per real fetch; data scrambled afterwards so a stale entry is never reused
    task automatic send(input logic [63:0] d, input level_t l, input acc_t a, input logic t, input logic p);
        @(posedge aclk);
        ent_valid    <= 1'b1;
        ent_data     <= d;
        ent_level    <= l;
        ent_acc      <= a;
        ent_table    <= t;
        ent_pae_load <= p;
        @(posedge aclk);
        ent_valid    <= 1'b0;
        ent_data     <= ~d;
    endtask : send
endmodule : walker_model
`default_nettype wire

// >>> testbench/guest_phys_entry_checker_tb.sv
// self-checking testbench for the second-stage entry checker
`timescale 1ns/1ns
`default_nettype none
module guest_phys_entry_checker_tb;
    import gpe_pkg::*;
    localparam int PAW = 40;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [3:0]  wstrb = 4'hf;
    logic [1:0]  bresp, rresp;
    logic        awready, wready, bvalid, arready, rvalid, res_valid, res_leaf;
    logic        ent_valid, ent_table, ent_pae_load, ignore_attr, accessed, dirty, suppress_vexc;
    logic        misconf_evt, viol_exit_evt, vexc_evt, conv_on;
    logic [63:0] ent_data;
    level_t      ent_level;
    acc_t        ent_acc;
    res_code_t   res_code;
    logic [51:0] page_addr;
    logic [2:0]  mem_type;
    int          fail_count = 0, samples_checked = 0, n_mis = 0, n_vio = 0;

    guest_phys_entry_checker #(.PA_WIDTH(PAW), .EXEC_ONLY_OK(1'b1), .CNT_WIDTH(16)) dut (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .ent_valid, .ent_data, .ent_level, .ent_acc, .ent_table, .ent_pae_load,
        .res_valid, .res_code, .res_leaf, .page_addr, .mem_type, .ignore_attr, .accessed, .dirty,
        .suppress_vexc, .misconf_evt, .viol_exit_evt, .vexc_evt);
    walker_model walker (.aclk, .ent_valid, .ent_data, .ent_level, .ent_acc, .ent_table, .ent_pae_load);

    // 10 MHz clock
    always #50 aclk = ~aclk;

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // a hung handshake ends the run straight away
    task automatic bail(input string what);
        fail_count++;
        $display("MISMATCH %s expected answer seen timeout", what);
        tally_and_finish();
    endtask : bail

    // address and data offered together, bready held until the response
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= d;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 20) bail("bvalid");
        r = bresp;
        bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 20) bail("rvalid");
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axi_read

    task automatic cfg(input logic c, input logic ad);
        logic [1:0] r;
        axi_write(OFF_CTRL, {31'h0, c}, r);
        axi_write(OFF_ROOT, {25'h0, ad, 6'h00}, r);
        chk("cfg_resp", RESP_OKAY, r);
        conv_on = c;
    endtask : cfg

    // one entry, then code and event pulses judged in the answer cycle
    task automatic probe(input logic [63:0] d, input level_t l, input acc_t a, input logic t, input logic p,
                         input res_code_t e);
        logic v;
        v = (e == RES_VIOL) || (e == RES_NOTPRES);
        n_mis += (e == RES_MISCONF);
        n_vio += v;
        walker.send(d, l, a, t, p);
        #1;
        chk("res_valid", 1, res_valid);
        chk("res_leaf", (l == LVL_LEAF) || (l != LVL_TOP && d[7]), res_leaf);
        chk("res_code", e, res_code);
        chk("misconf_evt", e == RES_MISCONF, misconf_evt);
        chk("vexc_evt", v && conv_on && !d[63], vexc_evt);
        chk("viol_exit_evt", v && !(conv_on && !d[63]), viol_exit_evt);
        @(posedge aclk);
        #1;
        chk("res_pulse", 0, res_valid);
    endtask : probe

    task automatic t_regs();
        logic [31:0] d;
        logic [1:0]  r;
        axi_read(OFF_CTRL, d, r);
        chk("ctrl_reset", CTRL_RST, d);
        axi_read(OFF_CAP, d, r);
        chk("cap", {16'h0000, PAW[7:0], 7'h00, 1'b1}, d);
        axi_write(8'h40, 32'hffff_ffff, r);
        chk("unmapped_wr", RESP_DECERR, r);
        axi_read(8'h40, d, r);
        chk("unmapped_rd", {RESP_DECERR, 32'h0000_0000}, {r, d});
        $display("test regs done");
    endtask : t_regs

    // every permission code against every access kind; leaf type 6 is legal
    task automatic t_perm();
        res_code_t  e;
        logic [2:0] g;
        cfg(1'b0, 1'b0);
        for (int i = 0; i < 8; i++) begin
            for (int k = 0; k < 3; k++) begin
                g = i[2:0];
                if (g == PERM_NONE) e = RES_NOTPRES;
                else if (g == PERM_WO || g == PERM_WX) e = RES_MISCONF;
                else if (g[k] == 1'b0) e = RES_VIOL;
                else e = RES_OK;
                probe({58'h0, 3'h6, g}, LVL_LEAF, acc_t'(k), 1'b0, 1'b0, e);
            end
        end
        $display("test perm done");
    endtask : t_perm

    task automatic t_rsvd();
        logic [63:0] b;
        b = 64'h0000_0000_0000_0037;
        probe(b | (64'h1 << PAW), LVL_LEAF, ACC_READ, 1'b0, 1'b0, RES_MISCONF);
        probe(b | (64'h1 << PAW), LVL_TOP, ACC_READ, 1'b0, 1'b0, RES_MISCONF);
        probe(b | (64'h1 << (PAW - 1)), LVL_LEAF, ACC_READ, 1'b0, 1'b0, RES_OK);
        probe(b | 64'h7ff0_0000_0000_0c80, LVL_LEAF, ACC_READ, 1'b0, 1'b0, RES_OK);
        probe(64'h0000_0000_0000_0017, LVL_LEAF, ACC_READ, 1'b0, 1'b0, RES_MISCONF);
        probe(64'h0000_0000_0000_001f, LVL_LEAF, ACC_READ, 1'b0, 1'b0, RES_MISCONF);
        probe(64'h0000_0000_0000_003f, LVL_LEAF, ACC_READ, 1'b0, 1'b0, RES_MISCONF);
        probe(64'h0000_0000_0000_00bf, LVL_DIR, ACC_READ, 1'b0, 1'b0, RES_MISCONF);
        probe(64'h0000_0000_0000_000f, LVL_DIR, ACC_READ, 1'b0, 1'b0, RES_MISCONF);
        probe(64'h0000_f000_0000_0038, LVL_LEAF, ACC_READ, 1'b0, 1'b0, RES_NOTPRES);
        $display("test reserved done");
    endtask : t_rsvd

    task automatic t_decode();
        logic [63:0] d;
        d = 64'h8000_00ab_cdef_1377;
        cfg(1'b1, 1'b1);
        probe(d, LVL_LEAF, ACC_FETCH, 1'b0, 1'b0, RES_OK);
        chk("page_addr", d & ((64'h1 << PAW) - 1) & ~64'h0fff, page_addr);
        chk("mem_type", d[5:3], mem_type);
        chk("ignore_attr", d[6], ignore_attr);
        chk("acc_dirty", d[9:8], {dirty, accessed});
        chk("suppress_vexc", d[63], suppress_vexc);
        cfg(1'b0, 1'b0);
        probe(d, LVL_LEAF, ACC_FETCH, 1'b0, 1'b0, RES_OK);
        chk("acc_dirty_off", 0, {suppress_vexc, dirty, accessed});
        $display("test decode done");
    endtask : t_decode

    task automatic t_events();
        cfg(1'b1, 1'b0);
        probe(64'h0, LVL_TOP, ACC_READ, 1'b0, 1'b0, RES_NOTPRES);
        probe(64'h8000_0000_0000_0000, LVL_TOP, ACC_READ, 1'b0, 1'b0, RES_NOTPRES);
        probe(64'h0000_0000_0000_0001, LVL_DIR, ACC_WRITE, 1'b0, 1'b0, RES_VIOL);
        probe(64'h0000_0000_0000_0006, LVL_DIR, ACC_READ, 1'b0, 1'b0, RES_MISCONF);
        cfg(1'b0, 1'b0);
        probe(64'h0, LVL_PTR, ACC_READ, 1'b0, 1'b0, RES_NOTPRES);
        $display("test events done");
    endtask : t_events

    // walker table reads under accessed/dirty, pointer loads, then silence with no fetch
    task automatic t_table();
        logic [31:0] d;
        logic [1:0]  r;
        cfg(1'b0, 1'b1);
        probe(64'h0000_0000_0000_0005, LVL_DIR, ACC_READ, 1'b1, 1'b0, RES_VIOL);
        probe(64'h0000_0000_0000_0005, LVL_DIR, ACC_READ, 1'b1, 1'b1, RES_OK);
        cfg(1'b0, 1'b0);
        probe(64'h0000_0000_0000_0005, LVL_DIR, ACC_READ, 1'b1, 1'b0, RES_OK);
        repeat (6) begin
            @(posedge aclk);
            #1;
            chk("idle", 0, {res_valid, misconf_evt, viol_exit_evt, vexc_evt});
        end
        // event counters and last result against what the scenarios sent
        axi_read(OFF_COUNTS, d, r);
        chk("counts", {n_vio[15:0], n_mis[15:0]}, d);
        axi_read(OFF_LAST, d, r);
        chk("last", 32'(RES_OK), d);
        $display("test table done");
    endtask : t_table

    // reset, then each scenario in turn
    initial begin
        conv_on = 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_perm();
        t_rsvd();
        t_decode();
        t_events();
        t_table();
        tally_and_finish();
    end
endmodule : guest_phys_entry_checker_tb
`default_nettype wire
